// >>> src/tvs_ctrl.sv
// Tuning word store controller: PWM, scale tracking, memory transfers
// How it works
// RULE1: A free-running 10-bit cycle counter steps at the oscillator rate.
// RULE2: PWM sets at counter zero and clears on counter equal tuning word.
// RULE3: The PWM period is 4 ms, delivered as 8 sub-pulses. The code gives a period of 1024 steps of 21 clocks, about 2.15 ms.
// RULE4: The 10-bit tuning word counts up/down or shifts serially.
// RULE5: Buttons are binary encoded; two presses never give a third code.
// RULE6: Of successive presses, the most recent button is selected.
// RULE7: On a press, drive slot address, raise read command, release data.
// RULE8: A read emits exactly 10 shift clocks into the tuning word.
// RULE9: The memory drives data during reads, one bit per shift clock.
// RULE10: In scale mode the comparator direction steps the word up or down.
// RULE11: Tracking first steps at about 250 Hz.
// RULE12: User holds store, presses a program, then releases store. In TVS_TRACK the code goes to TVS_IDLE on the press, then back to TVS_TRACK.
// RULE13: After store, step rate slows steadily over 1 second. The code raises step_div with step_cnt each clock: at most one step.
// RULE14: Then raise write command, drive data, emit 10 shift clocks.
// RULE15: The memory floats its data output during a write.
// RULE16: When busy falls, the same slot is read back to verify.
// RULE17: Mute is high throughout any program change or store.
// RULE18: With only store held, mute drops once the comparator matches.
// RULE19: A power-on rise starts a program change if a button is held.
// RULE20: A fourth slot address bit gives 16 stations.
// RULE21: Words shift most significant bit first in both directions.
// RULE22: Buttons count only after being stable for several clock periods.
`default_nettype none
module tvs_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic link_clk_in,
  input wire logic [tvs_pkg::BTN_N-1:0] program_button_in,
  input wire logic store_button_in,
  input wire logic bank_select_in,
  input wire logic compare_up_in,
  input wire logic write_busy_in,
  input wire logic power_on_in,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe_out,
  output logic [tvs_pkg::SLOT_W-1:0] slot_address_out,
  output logic read_command_out,
  output logic write_command_out,
  output logic shift_clock_out,
  output logic pwm_out,
  output logic mute_out,
  output logic memory_reset_out,
  output logic [tvs_pkg::WORD_W-1:0] tuning_word_out
);
  typedef struct packed {
    logic [4:0] osc_div;
    logic [tvs_pkg::WORD_W-1:0] cycle;
    logic pwm;
    logic [tvs_pkg::WORD_W-1:0] word;
    logic [tvs_pkg::BTN_N-1:0] btn_s1;
    logic [tvs_pkg::BTN_N-1:0] btn_s2;
    logic [tvs_pkg::BTN_N-1:0] btn_prev;
    logic [tvs_pkg::BTN_N-1:0] btn_stable;
    logic [15:0] db_cnt;
    // Pin levels: bank, power-on, busy, compare, store
    logic [4:0] ctl_s1;
    logic [4:0] ctl_s2;
    logic por_prev;
    logic busy_seen;
    logic cmp_prev;
    logic locked;
    logic [2:0] sel;
    tvs_pkg::tvs_state_type state;
    logic [23:0] step_cnt;
    logic [23:0] step_div;
    logic [23:0] retune_cnt;
    logic [3:0] bits;
    logic [15:0] half_cnt;
    logic mute;
    tvs_pkg::tvs_mem_type mem;
  } tvs_regs_type;

  tvs_regs_type r, next_r;
  logic [3:0] pick;
  logic any_new;
  logic store_held;
  logic up;
  logic busy;
  logic por;
  logic bank;
  logic frame_low;
  logic [7:0] sub_pos;
  logic [7:0] clear_at;
  logic deb_restart;
  logic store_only;
  logic [tvs_pkg::BTN_N-1:0] new_press;

  // Link-clocked capture of the memory data pin, two stages
  logic link_s1;
  logic link_s2;
  always_ff @(posedge link_clk_in) begin
    link_s1 <= serial_data_io_in;
    link_s2 <= link_s1;
  end
  // Level into the system domain through two more flops
  logic dat_s1;
  logic dat_s2;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else if (ce_in) begin
      dat_s1 <= link_s2;
      dat_s2 <= dat_s1;
    end
  end

  // Lowest-numbered fresh press; a lone fresh bit gives its exact code
  always_comb begin
    new_press = r.btn_stable & ~r.btn_prev;
    pick = 4'h8;
    for (int i = tvs_pkg::BTN_N - 1; i >= 0; i--) begin
      if (new_press[i]) begin
        pick = 4'(i);
      end
    end
  end

  always_comb begin
    next_r = r;
    any_new = !pick[3];
    store_held = r.ctl_s2[0];
    up = r.ctl_s2[1];
    busy = r.ctl_s2[2];
    por = r.ctl_s2[3];
    bank = r.ctl_s2[4];
    // Frames below the low word bits get one extra step of width
    frame_low = r.cycle[tvs_pkg::WORD_W-1:tvs_pkg::SUB_W] < r.word[2:0];
    sub_pos = {1'b0, r.cycle[tvs_pkg::SUB_W-1:0]};
    clear_at = {1'b0, r.word[tvs_pkg::WORD_W-1:tvs_pkg::WORD_W-tvs_pkg::SUB_W]}
      + {7'h00, frame_low};
    // Any bounce, or no change at all, restarts the stability window
    deb_restart = (r.btn_s2 == ~r.btn_stable) || (r.btn_s2 != r.btn_s1);
    store_only = (r.state == tvs_pkg::TVS_IDLE) ||
      (r.state == tvs_pkg::TVS_TRACK);
    next_r.btn_s1 = program_button_in; // RULE22
    next_r.btn_s2 = r.btn_s1;
    next_r.ctl_s1 = {bank_select_in, power_on_in, write_busy_in,
      compare_up_in, store_button_in};
    next_r.ctl_s2 = r.ctl_s1;
    next_r.por_prev = r.ctl_s2[3];
    next_r.mem.read_cmd = 1'b0;
    next_r.mem.write_cmd = 1'b0;
    // Cycle counter advance at oscillator rate
    if (r.osc_div == tvs_pkg::OSC_DIV_LAST) begin
      next_r.osc_div = 5'h00;
      next_r.cycle = r.cycle + tvs_pkg::WORD_ONE; // RULE1
      // Sub-pulse frame of 7 bits: set at start, clear on word match
      if (r.cycle[tvs_pkg::SUB_W-1:0] == 7'h00) begin
        next_r.pwm = (r.word != tvs_pkg::WORD_ZERO); // RULE2 RULE3
      end
      if (sub_pos == clear_at) begin
        next_r.pwm = 1'b0; // RULE2 RULE3
      end
    end else begin
      next_r.osc_div = r.osc_div + 5'h01;
    end
    // Debounce: stable for the full window before accepted
    if (deb_restart) begin
      next_r.db_cnt = 16'h0000;
    end else if (r.db_cnt == 16'(tvs_pkg::DEBOUNCE_CYC)) begin
      next_r.btn_stable = ~r.btn_s2; // RULE22
      next_r.db_cnt = 16'h0000;
    end else begin
      next_r.db_cnt = r.db_cnt + 16'h0001;
    end
    next_r.btn_prev = r.btn_stable;
    // Latest single new press wins; a double press is locked out
    if (any_new && $onehot(new_press)) begin
      next_r.sel = pick[2:0]; // RULE5 RULE6
    end
    // In idle and tracking states mute follows store and the comparator
    if (store_only) begin
      next_r.mute = store_held && !r.locked; // RULE18
      if (store_held && r.cmp_prev != up) begin
        next_r.locked = 1'b1; // RULE18
      end
      if (!store_held) begin
        next_r.locked = 1'b0;
      end
      next_r.cmp_prev = up;
    end
    case (r.state)
      tvs_pkg::TVS_IDLE: begin
        if ((any_new && $onehot(new_press)) ||
            (por && !r.por_prev && |r.btn_stable)) begin // RULE19
          next_r.mem.slot = {bank,
            any_new ? pick[2:0] : r.sel}; // RULE7 RULE20
          next_r.sel = any_new ? pick[2:0] : r.sel;
          next_r.mute = 1'b1; // RULE17
          next_r.mem.data_oe = 1'b0; // RULE7
          next_r.mem.read_cmd = 1'b1; // RULE7
          next_r.bits = tvs_pkg::SHIFT_BITS;
          next_r.half_cnt = 16'h0000;
          next_r.state = store_held ? tvs_pkg::TVS_RETUNE
            : tvs_pkg::TVS_READ;
          next_r.step_div = 24'(tvs_pkg::FAST_DIV);
          next_r.retune_cnt = 24'h000000;
        end else if (store_held) begin
          next_r.state = tvs_pkg::TVS_TRACK;
          next_r.step_div = 24'(tvs_pkg::FAST_DIV); // RULE11
        end
      end
      tvs_pkg::TVS_TRACK, tvs_pkg::TVS_RETUNE: begin
        if (r.step_cnt >= r.step_div) begin
          next_r.step_cnt = 24'h000000;
          next_r.word = up ? r.word + tvs_pkg::WORD_ONE
            : r.word - tvs_pkg::WORD_ONE; // RULE4 RULE10
        end else begin
          next_r.step_cnt = r.step_cnt + 24'h000001;
        end
        if (r.state == tvs_pkg::TVS_RETUNE) begin
          next_r.mute = 1'b1; // RULE17
          next_r.retune_cnt = r.retune_cnt + 24'h000001;
          next_r.step_div = r.step_div + 24'h000001; // RULE13
          if (r.retune_cnt == 24'(tvs_pkg::RETUNE_CYC)) begin
            next_r.state = tvs_pkg::TVS_WRITE; // RULE14
            next_r.mem.write_cmd = 1'b1;
            next_r.mem.data_oe = 1'b1;
            next_r.mem.data_o = r.word[tvs_pkg::WORD_W-1]; // RULE21
            next_r.bits = tvs_pkg::SHIFT_BITS;
            next_r.half_cnt = 16'h0000;
          end
        end else if (!store_held) begin
          next_r.state = tvs_pkg::TVS_IDLE;
        end else if (any_new && $onehot(new_press)) begin
          next_r.state = tvs_pkg::TVS_IDLE; // RULE12
        end
      end
      tvs_pkg::TVS_READ, tvs_pkg::TVS_WRITE: begin
        next_r.mute = 1'b1; // RULE17
        next_r.mem.read_cmd = (r.state == tvs_pkg::TVS_READ);
        next_r.mem.write_cmd = (r.state == tvs_pkg::TVS_WRITE);
        if (r.half_cnt == 16'(tvs_pkg::SHIFT_HALF)) begin
          next_r.half_cnt = 16'h0000;
          next_r.mem.shift_clk = !r.mem.shift_clk;
          if (r.mem.shift_clk) begin
            next_r.bits = r.bits - 4'h1; // RULE8 RULE14
            if (r.state == tvs_pkg::TVS_READ) begin
              next_r.word = {r.word[tvs_pkg::WORD_W-2:0], dat_s2}; // RULE4 RULE8 RULE21
            end else begin
              next_r.word = {r.word[tvs_pkg::WORD_W-2:0],
                r.word[tvs_pkg::WORD_W-1]}; // RULE21
              next_r.mem.data_o = r.word[tvs_pkg::WORD_W-2];
            end
            if (r.bits == 4'h1) begin
              next_r.mem.read_cmd = 1'b0;
              next_r.mem.write_cmd = 1'b0;
              next_r.mem.data_oe = 1'b0;
              next_r.busy_seen = 1'b0;
              next_r.state = (r.state == tvs_pkg::TVS_WRITE)
                ? tvs_pkg::TVS_WAIT : tvs_pkg::TVS_IDLE;
            end
          end
        end else begin
          next_r.half_cnt = r.half_cnt + 16'h0001;
        end
      end
      tvs_pkg::TVS_WAIT: begin
        next_r.mute = 1'b1; // RULE17
        if (busy) begin
          next_r.busy_seen = 1'b1;
        end else if (r.busy_seen) begin
          next_r.state = tvs_pkg::TVS_READ; // RULE16
          next_r.mem.read_cmd = 1'b1;
          next_r.bits = tvs_pkg::SHIFT_BITS;
          next_r.half_cnt = 16'h0000;
        end
      end
      default: begin
        next_r.state = tvs_pkg::TVS_IDLE;
      end
    endcase
    next_r.mem.reset_mem = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign serial_data_io_out = r.mem.data_o;
  assign serial_data_io_oe_out = r.mem.data_oe;
  assign slot_address_out = r.mem.slot;
  assign read_command_out = r.mem.read_cmd;
  assign write_command_out = r.mem.write_cmd;
  assign shift_clock_out = r.mem.shift_clk;
  assign pwm_out = r.pwm;
  assign mute_out = r.mute;
  assign memory_reset_out = r.mem.reset_mem;
  assign tuning_word_out = r.word;
endmodule
`default_nettype wire

// >>> src/tvs_pkg.sv
// Package: constants, states and carrier structs of the tuning voltage store
`default_nettype none
package tvs_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OSC_HZ = 455_000;
  localparam int unsigned WORD_W = 10;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned BTN_N = 8;
  // One cycle-counter step per oscillator cycle: a 10-bit counter at OSC_HZ
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [4:0] OSC_DIV_LAST = 5'(OSC_DIV - 1);
  // Period of 1024 counter steps (about 2.15 ms) split into 8 pulses: top 3 counter bits pick the sub-pulse
  localparam int unsigned PERIOD_MS = 4;
  localparam int unsigned SUB_PULSES = 8;
  localparam int unsigned SUB_W = 7;
  localparam int unsigned FAST_HZ = 250;
  localparam int unsigned FAST_DIV = CLK_HZ / FAST_HZ;
  localparam int unsigned RETUNE_MS = 1000;
  localparam int unsigned RETUNE_CYC = CLK_HZ / 1000 * RETUNE_MS;
  localparam int unsigned DEBOUNCE_CYC = 8 * OSC_DIV;
  localparam int unsigned SHIFT_HALF = 4 * OSC_DIV;
  localparam logic [3:0] SHIFT_BITS = 4'ha;
  localparam logic [WORD_W-1:0] WORD_ZERO = 10'h000;
  localparam logic [WORD_W-1:0] WORD_ONE = 10'h001;
  localparam logic [2:0] PH_READ = 3'h0;

  typedef enum logic [2:0] {
    TVS_IDLE = 3'b000,
    TVS_READ = 3'b001,
    TVS_RETUNE = 3'b011,
    TVS_WRITE = 3'b010,
    TVS_WAIT = 3'b110,
    TVS_TRACK = 3'b111
  } tvs_state_type;

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic read_cmd;
    logic write_cmd;
    logic shift_clk;
    logic data_o;
    logic data_oe;
    logic reset_mem;
  } tvs_mem_type;
endpackage
`default_nettype wire

// >>> verification/tuning_voltage_store_control_tb.sv
// Testbench: program change, button handling and scale tracking
`default_nettype none
module tuning_voltage_store_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, lclk = 0, rst = 1, st = 0, bank = 0, up = 1, pon = 1;
  logic [7:0] btn = 8'hff;
  logic dout, doe, m_d, m_oe, busy, sd, sd_q = 0, rd, wr, sc, pwm, mute;
  logic [3:0] slot;
  logic [9:0] word, w0;
  int miscompares = 0, check_count = 0, cycles = 0;
  always #50 clk = ~clk;
  initial begin
    #2.3;
    forever #6 lclk = ~lclk;
  end
  // Released line shows a changing pattern, never the last value
  assign sd = doe ? dout : m_oe ? m_d : ~sd_q;
  always @(posedge lclk) sd_q <= sd;
  tvs_ctrl u_dut (.clk_in(clk), .rst_in(rst), .ce_in(1'b1),
    .link_clk_in(lclk), .program_button_in(btn), .store_button_in(st),
    .bank_select_in(bank), .compare_up_in(up), .write_busy_in(busy),
    .power_on_in(pon), .serial_data_io_in(sd),
    .serial_data_io_out(dout), .serial_data_io_oe_out(doe),
    .slot_address_out(slot), .read_command_out(rd),
    .write_command_out(wr), .shift_clock_out(sc), .pwm_out(pwm),
    .mute_out(mute), .memory_reset_out(), .tuning_word_out(word));
  tvs_mem_model u_mem (.shift_clk_in(sc), .read_cmd_in(rd),
    .write_cmd_in(wr), .slot_in(slot), .data_in(sd), .data_out(m_d),
    .data_oe_out(m_oe), .busy_out(busy));
  function automatic logic [9:0] val(input int i);
    return 10'h2c5 ^ 10'(i * 37);
  endfunction
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_rd(input logic want, input int lim);
    for (int n = 0; n < lim && rd !== want; n++) @(negedge clk);
  endtask
  task automatic settle;
    btn = 8'hff;
    repeat (300) @(negedge clk);
  endtask
  // Press a button, keep it held, follow the whole read transfer
  task automatic prog(input int n, input logic [3:0] s);
    btn[n] = 0;
    wait_rd(1, 600);
    chk({9'h0, rd}, 10'h1);
    chk({6'h0, slot}, {6'h0, s});
    chk({9'h0, mute}, 10'h1);
    wait_rd(0, 3000);
    repeat (20) @(negedge clk);
    chk(word, val(s));
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) u_mem.mem[i] = val(i);
    repeat (16) @(negedge clk);
    rst = 0;
    chk({rd, wr, mute, doe, word[5:0]}, 10'h0);
    for (int i = 0; i < 8; i++) begin
      prog(i, 4'(i));
      settle;
    end
    bank = 1;
    prog(3, 4'hb);
    prog(5, 4'hd);
    bank = 0;
    settle;
    btn[4] = 0;
    repeat (50) @(negedge clk);
    btn[4] = 1;
    wait_rd(1, 500);
    chk({9'h0, rd}, 10'h0);
    btn = 8'hbd;
    wait_rd(1, 600);
    chk({9'h0, rd}, 10'h0);
    wait_rd(0, 3000);
    settle;
    pon = 0;
    prog(2, 4'h2);
    pon = 1;
    wait_rd(1, 600);
    chk({9'h0, rd}, 10'h1);
    chk({6'h0, slot}, 10'h002);
    wait_rd(0, 3000);
    settle;
    w0 = word;
    st = 1;
    repeat (200) @(negedge clk);
    chk({9'h0, mute}, 10'h1);
    for (int n = 0; n < 41000 && word === w0; n++) @(negedge clk);
    chk(word, w0 + 10'h001);
    up = 0;
    for (int n = 0; n < 41000 && mute !== 1'b0; n++) @(negedge clk);
    chk({9'h0, mute}, 10'h0);
    st = 0;
    end_sim;
  end
endmodule
`default_nettype wire

// >>> verification/tvs_mem_model.sv
// Behavioural serial tuning memory on the far side of the controller
`default_nettype none
module tvs_mem_model (
  input wire logic shift_clk_in,
  input wire logic read_cmd_in,
  input wire logic write_cmd_in,
  input wire logic [3:0] slot_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] mem [16];
  logic [9:0] wr;
  int idx = 9;
  bit first;
  assign data_oe_out = read_cmd_in;
  assign data_out = mem[slot_in][idx];
  always @(posedge read_cmd_in) begin
    idx = 9;
    first = 1;
  end
  // Next bit appears on each rise after the first, held over the fall
  always @(posedge shift_clk_in) begin
    if (read_cmd_in && first) first = 0;
    else if (read_cmd_in && idx > 0) idx = idx - 1;
  end
  always @(negedge shift_clk_in) begin
    if (write_cmd_in) wr = {wr[8:0], data_in};
  end
  initial busy_out = 0;
  always @(negedge write_cmd_in) begin
    mem[slot_in] = wr;
    busy_out = 1;
    #20000 busy_out = 0;
  end
endmodule
`default_nettype wire

// >>> verification/tvs_monitor.sv
// Checker of transfer, mute, pulse and tracking behaviour at the ports
`default_nettype none
module tvs_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic store_button_in,
  input wire logic compare_up_in,
  input wire logic serial_data_io_oe_out,
  input wire logic [3:0] slot_address_out,
  input wire logic read_command_out,
  input wire logic write_command_out,
  input wire logic shift_clock_out,
  input wire logic pwm_out,
  input wire logic mute_out,
  input wire logic [9:0] tuning_word_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic sc_q;
  int shifts;
  int gap;
  // Shift pulses per read, and low time of the pulse output
  always_ff @(posedge clk_in) begin
    sc_q <= shift_clock_out;
    if (rst_in || !read_command_out) shifts <= 0;
    else if (shift_clock_out && !sc_q) shifts <= shifts + 1;
    if (rst_in || pwm_out || tuning_word_out < 10'h040 ||
        tuning_word_out > 10'h3c0) gap <= 0;
    else gap <= gap + 1;
  end
  sequence s_half; shift_clock_out [*8]; endsequence
  property p_mute;
    (read_command_out || write_command_out) |-> mute_out;
  endproperty
  property p_float; read_command_out |-> !serial_data_io_oe_out; endproperty
  property p_drive;
    write_command_out && shift_clock_out |-> serial_data_io_oe_out;
  endproperty
  property p_count; $fell(read_command_out) |-> shifts == 10; endproperty
  property p_slot;
    read_command_out && $past(read_command_out) |-> $stable(slot_address_out);
  endproperty
  property p_half; $rose(shift_clock_out) |-> s_half; endproperty
  property p_gap; gap < 3000; endproperty
  property p_step;
    store_button_in && !read_command_out && !write_command_out &&
      compare_up_in == $past(compare_up_in, 8) &&
      $changed(tuning_word_out) |-> tuning_word_out ==
      $past(tuning_word_out) + (compare_up_in ? 10'h001 : 10'h3ff);
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute low during a transfer");
  a_float: assert property (p_float)
    else $error("data pin driven during a read");
  a_drive: assert property (p_drive)
    else $error("data pin not driven during a write");
  a_count: assert property (p_count)
    else $error("read did not give ten shift clocks");
  a_slot: assert property (p_slot)
    else $error("slot address moved during a read");
  a_half: assert property (p_half)
    else $error("shift clock pulse too short");
  a_gap: assert property (p_gap)
    else $error("pulse output stuck low past a frame");
  a_step: assert property (p_step)
    else $error("tracking step not one count in compare direction");
endmodule
bind tvs_ctrl tvs_monitor u_mon (.clk_in, .rst_in, .store_button_in,
  .compare_up_in, .serial_data_io_oe_out, .slot_address_out,
  .read_command_out, .write_command_out, .shift_clock_out, .pwm_out,
  .mute_out, .tuning_word_out);
`default_nettype wire
